// File: prot_host_pkg.sv
/*
  Shared constants and types for the protection-space command controller.
  Assumes one 125 MHz clock and a x16 asynchronous flash on plain pins.
*/
// Functional notes
// - 0xF0 from a space idle returns array read
// - 0x70 at 0x555, next read returns status
// - Exit is 0x90 then 0x00
// - Persistent: 0xA0, then 0x00 starts bit program
// - Persistent: 0x80, then 0x30 at 0 erases all
// - 0x71 at 0x555 clears status, stays idle; from the program-busy space the code returns to array read
// - Lock-bit space: 0xA0 then 0x00 sets lock bit
// - Volatile: 0xA0, sector write 0x00 set, 0x01 clear
package prot_host_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int T_SETUP_NS    = 10;
  localparam int T_WE_PULSE_NS = 35;
  localparam int T_ACCESS_NS   = 100;
  localparam int T_HOLD_NS     = 20;
  localparam int SYNC_STAGES   = 2;

  // Least times round up to whole cycles
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WE_CYC    = 8'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RD_CYC    = 8'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                        + SYNC_STAGES);
  localparam logic [7:0] HOLD_CYC  = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [31:0] A_UNLOCK = 32'h0000_0555;
  localparam logic [15:0] D_RESET       = 16'h00f0;
  localparam logic [15:0] D_STAT_READ   = 16'h0070;
  localparam logic [15:0] D_STAT_CLEAR  = 16'h0071;
  localparam logic [15:0] D_EXIT_ENTRY  = 16'h0090;
  localparam logic [15:0] D_ZERO        = 16'h0000;
  localparam logic [15:0] D_PROG_ENTRY  = 16'h00a0;
  localparam logic [15:0] D_VOL_CLEAR   = 16'h0001;
  localparam logic [15:0] D_ERASE_ENTER = 16'h0080;
  localparam logic [15:0] D_ERASE_START = 16'h0030;

  localparam int SR_READY_BIT = 7;
  localparam int LR_GUARD_A   = 2;
  localparam int LR_GUARD_B   = 5;

  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_SPACE    = 8'h08;
  localparam logic [7:0] REG_LOCK     = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_RDATA    = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;

  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_SPACE_LSB = 4;
  localparam int ST_SR_LSB    = 8;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_REFUSED  = 1;
  localparam int IRQ_W        = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    OP_RESET  = 4'h0, OP_STATUS = 4'h1, OP_CLEAR  = 4'h2, OP_EXIT = 4'h3,
    OP_PPROG  = 4'h4, OP_PERASE = 4'h5, OP_LBSET  = 4'h6, OP_VSET = 4'h7,
    OP_VCLR   = 4'h8, OP_READ   = 4'h9
  } op_e;

  typedef enum logic [2:0] {
    SP_ARRAY = 3'h0, SP_PERSIST = 3'h1, SP_PBUSY = 3'h2, SP_LOCKBIT = 3'h3, SP_VOLATILE = 3'h4
  } space_e;

  typedef enum logic [1:0] {ACT_END = 2'h0, ACT_WR = 2'h1, ACT_RD = 2'h2, ACT_POLL = 2'h3} act_e;
  typedef enum logic [1:0] {AD_ANY = 2'h0, AD_UNLOCK = 2'h1, AD_ZERO = 2'h2, AD_USER = 2'h3} asel_e;

  typedef struct packed {
    act_e        act;
    asel_e       asel;
    logic [15:0] data;
  } step_s;

  typedef struct packed {
    logic        rd;
    logic [31:0] addr;
    logic [15:0] data;
  } cyc_req_s;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
  } pins_s;

endpackage : prot_host_pkg

// File: pin_sync.sv
/*
  Two-stage synchroniser for pin inputs.
  Assumes inputs are asynchronous to aclk; only stage two is read.
*/
module pin_sync #(
  parameter int W = 16
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : pin_sync

// File: flash_cycle_engine.sv
/*
  One flash bus cycle per request: setup, strobe pulse, hold.
  Assumes dq_i already synchronised; the read pulse covers that delay.
*/
module flash_cycle_engine import prot_host_pkg::*; #(
  parameter int AW = 26,
  parameter int DW = 16
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire cyc_req_s      req,
  output logic               done,
  output logic      [DW-1:0] rdata,
  output pins_s              pins,
  output logic      [AW-1:0] fl_addr,
  output logic      [DW-1:0] dq_o,
  output logic               dq_oe,
  input  wire logic [DW-1:0] dq_i_sync
);

  typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_SETUP = 2'h1, PH_PULSE = 2'h2, PH_HOLD = 2'h3} ph_e;

  ph_e        ph_q;
  logic [7:0] cnt_q;
  logic       rd_q;

  assign req_ready = (ph_q == PH_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_q    <= PH_IDLE;
      cnt_q   <= 8'h00;
      rd_q    <= 1'b0;
      done    <= 1'b0;
      rdata   <= '0;
      pins    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      fl_addr <= '0;
      dq_o    <= '0;
      dq_oe   <= 1'b0;
    end else begin
      done <= 1'b0;
      case (ph_q)
        PH_IDLE: begin
          if (req_valid) begin
            ph_q      <= PH_SETUP;
            cnt_q     <= SETUP_CYC - 8'h01;
            rd_q      <= req.rd;
            fl_addr   <= req.addr[AW-1:0];
            dq_o      <= req.data[DW-1:0];
            dq_oe     <= !req.rd;
            pins.ce_n <= 1'b0;
          end
        end
        PH_SETUP: begin
          if (cnt_q == 8'h00) begin
            ph_q  <= PH_PULSE;
            cnt_q <= rd_q ? RD_CYC - 8'h01 : WE_CYC - 8'h01;
            if (rd_q) pins.oe_n <= 1'b0;
            else pins.we_n <= 1'b0;
          end else cnt_q <= cnt_q - 8'h01;
        end
        PH_PULSE: begin
          if (cnt_q == 8'h00) begin
            ph_q      <= PH_HOLD;
            cnt_q     <= HOLD_CYC - 8'h01;
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            if (rd_q) rdata <= dq_i_sync;
          end else cnt_q <= cnt_q - 8'h01;
        end
        PH_HOLD: begin
          if (cnt_q == 8'h00) begin
            ph_q      <= PH_IDLE;
            pins.ce_n <= 1'b1;
            dq_oe     <= 1'b0;
            done      <= 1'b1;
          end else cnt_q <= cnt_q - 8'h01;
        end
        default: ph_q <= PH_IDLE;
      endcase
    end
  end

endmodule : flash_cycle_engine

// File: prot_space_host.sv
/*
  Host controller that drives the flash protection-space command sequences.
  Software reaches it over AXI4-Lite; the flash sits on plain async pins.
  Assumes the flash was placed in a protection space by other logic and
  software reports which one through the space register.
*/
module prot_space_host import prot_host_pkg::*; #(
  parameter int AW = 26,
  parameter int DW = 16
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [AW-1:0]      fl_addr,
  output logic [DW-1:0]      fl_dq_o,
  output logic               fl_dq_oe,
  input  wire logic [DW-1:0] fl_dq_i,
  output logic               fl_ce_n,
  output logic               fl_we_n,
  output logic               fl_oe_n,
  output logic               irq
);

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_ISSUE = 3'h1, S_WAIT = 3'h2,
    S_POLL_CMD = 3'h3, S_POLL_RD = 3'h4, S_POLL_WAIT = 3'h5
  } state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Command tables

  function automatic step_s step_f(input op_e op, input logic [1:0] idx);
    step_s s;
    s = '{act: ACT_END, asel: AD_ANY, data: D_ZERO};
    case (op)
      OP_RESET:  if (idx == 2'd0) s = '{ACT_WR, AD_ANY, D_RESET};
      OP_STATUS: begin
        if (idx == 2'd0) s = '{ACT_WR, AD_UNLOCK, D_STAT_READ};
        else if (idx == 2'd1) s = '{ACT_RD, AD_USER, D_ZERO};
      end
      OP_CLEAR:  if (idx == 2'd0) s = '{ACT_WR, AD_UNLOCK, D_STAT_CLEAR};
      OP_EXIT: begin
        if (idx == 2'd0) s = '{ACT_WR, AD_ANY, D_EXIT_ENTRY};
        else if (idx == 2'd1) s = '{ACT_WR, AD_ANY, D_ZERO};
      end
      OP_PPROG: begin
        // Request state after A0 is not yet busy; 00 starts it
        if (idx == 2'd0) s = '{ACT_WR, AD_ANY, D_PROG_ENTRY};
        else if (idx == 2'd1) s = '{ACT_WR, AD_USER, D_ZERO};
        else if (idx == 2'd2) s = '{ACT_POLL, AD_UNLOCK, D_STAT_READ};
      end
      OP_PERASE: begin
        if (idx == 2'd0) s = '{ACT_WR, AD_ANY, D_ERASE_ENTER};
        else if (idx == 2'd1) s = '{ACT_WR, AD_ZERO, D_ERASE_START};
        else if (idx == 2'd2) s = '{ACT_POLL, AD_UNLOCK, D_STAT_READ};
      end
      OP_LBSET: begin
        if (idx == 2'd0) s = '{ACT_WR, AD_ANY, D_PROG_ENTRY};
        else if (idx == 2'd1) s = '{ACT_WR, AD_ANY, D_ZERO};
      end
      OP_VSET, OP_VCLR: begin
        if (idx == 2'd0) s = '{ACT_WR, AD_ANY, D_PROG_ENTRY};
        else if (idx == 2'd1) s = '{ACT_WR, AD_USER, (op == OP_VCLR) ? D_VOL_CLEAR : D_ZERO};
      end
      OP_READ:   if (idx == 2'd0) s = '{ACT_RD, AD_USER, D_ZERO};
      default:   s = '{act: ACT_END, asel: AD_ANY, data: D_ZERO};
    endcase
    return s;
  endfunction : step_f

  // Only commands defined for the space are sent
  function automatic logic allowed_f(input op_e op, input space_e sp, input logic [7:0] lr);
    logic common;
    common = (op == OP_RESET) || (op == OP_STATUS) || (op == OP_CLEAR) || (op == OP_READ);
    case (sp)
      SP_PERSIST:  return common || op == OP_EXIT || op == OP_PPROG || op == OP_PERASE;
      SP_PBUSY:    return common;
      SP_LOCKBIT:  return common || op == OP_EXIT ||
                          (op == OP_LBSET && !lr[LR_GUARD_A] && !lr[LR_GUARD_B]);
      SP_VOLATILE: return common || op == OP_EXIT || op == OP_VSET || op == OP_VCLR;
      default:     return 1'b0;
    endcase
  endfunction : allowed_f

  function automatic space_e next_space_f(input op_e op, input space_e sp);
    case (op)
      OP_RESET, OP_EXIT: return SP_ARRAY;
      OP_CLEAR:          return (sp == SP_PBUSY) ? SP_ARRAY : sp;
      OP_PPROG, OP_PERASE: return SP_PBUSY;
      default:           return sp;
    endcase
  endfunction : next_space_f

  function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : merge_f

  ////////////////////////////////////////////////////////////////////////////
  // Register slave

  logic        aw_have_q, w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [31:0] user_addr_q;
  logic [7:0]  lock_q;
  space_e      space_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic [15:0] sr_q, rdata_q;
  state_e      state_q;
  op_e         op_q;
  logic [1:0]  idx_q;

  logic        aw_hs, w_hs, wr_fire, ar_hs, wr_hit, rd_hit;
  logic [7:0]  wa;
  logic [31:0] wd, rd_mux;
  logic [3:0]  ws;
  op_e         cmd_op;
  logic        cmd_wr, cmd_ok, busy;
  logic        eng_req_was_rd_q;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign aw_hs   = s_axi_awvalid && s_axi_awready;
  assign w_hs    = s_axi_wvalid && s_axi_wready;
  assign ar_hs   = s_axi_arvalid && s_axi_arready;
  assign wr_fire = (aw_have_q || aw_hs) && (w_have_q || w_hs) && !s_axi_bvalid;
  assign wa      = aw_have_q ? awaddr_q : s_axi_awaddr;
  assign wd      = w_have_q ? wdata_q : s_axi_wdata;
  assign ws      = w_have_q ? wstrb_q : s_axi_wstrb;
  assign wr_hit  = (wa[7:2] <= REG_IRQ_MASK[7:2]) && (wa[1:0] == 2'b00);
  assign rd_hit  = (s_axi_araddr[7:2] <= REG_IRQ_MASK[7:2]) && (s_axi_araddr[1:0] == 2'b00);
  assign busy    = (state_q != S_IDLE);
  assign cmd_op  = op_e'(wd[3:0]);
  assign cmd_wr  = wr_fire && (wa == REG_CMD) && ws[0];
  assign cmd_ok  = !busy && allowed_f(cmd_op, space_q, lock_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (aw_hs && !wr_fire) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_hs && !wr_fire) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_addr_q <= 32'h0000_0000;
      lock_q      <= 8'h00;
      irq_mask_q  <= '0;
    end else if (wr_fire) begin
      if (wa == REG_ADDR) user_addr_q <= merge_f(user_addr_q, wd, ws);
      if (wa == REG_LOCK && ws[0]) lock_q <= wd[7:0];
      if (wa == REG_IRQ_MASK && ws[0]) irq_mask_q <= wd[IRQ_W-1:0];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      REG_ADDR:     rd_mux = user_addr_q;
      REG_SPACE:    rd_mux[2:0] = space_q;
      REG_LOCK:     rd_mux[7:0] = lock_q;
      REG_STATUS: begin
        rd_mux[ST_BUSY_BIT] = busy;
        rd_mux[ST_SPACE_LSB +: 3] = space_q;
        rd_mux[ST_SR_LSB +: 16] = sr_q;
      end
      REG_RDATA:    rd_mux[15:0] = rdata_q;
      REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
      REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: a read clears, but a new event in that cycle survives

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_stat_q <= '0;
    else if (ar_hs && s_axi_araddr == REG_IRQ_STAT) irq_stat_q <= irq_set;
    else irq_stat_q <= irq_stat_q | irq_set;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  step_s      cur;
  cyc_req_s   eng_req;
  logic       eng_valid, eng_ready, eng_done;
  logic [DW-1:0] eng_rdata, dq_sync;
  pins_s      pins;
  logic [31:0] step_addr;

  assign cur = step_f(op_q, idx_q);

  always_comb begin
    case (cur.asel)
      AD_UNLOCK: step_addr = A_UNLOCK;
      AD_USER:   step_addr = user_addr_q;
      default:   step_addr = 32'h0000_0000;
    endcase
  end

  always_comb begin
    eng_valid = 1'b0;
    eng_req   = '{rd: 1'b0, addr: step_addr, data: cur.data};
    case (state_q)
      S_ISSUE:    eng_valid = (cur.act == ACT_WR) || (cur.act == ACT_RD);
      S_POLL_CMD: begin
        eng_valid = 1'b1;
        eng_req   = '{rd: 1'b0, addr: A_UNLOCK, data: D_STAT_READ};
      end
      S_POLL_RD: begin
        eng_valid = 1'b1;
        eng_req   = '{rd: 1'b1, addr: user_addr_q, data: D_ZERO};
      end
      default:    eng_valid = 1'b0;
    endcase
    if (state_q == S_ISSUE) eng_req.rd = (cur.act == ACT_RD);
  end

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_REFUSED] = cmd_wr && !cmd_ok;
    irq_set[IRQ_DONE] = (state_q == S_ISSUE) && (cur.act == ACT_END);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      op_q    <= OP_RESET;
      idx_q   <= 2'd0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmd_wr && cmd_ok) begin
            op_q    <= cmd_op;
            idx_q   <= 2'd0;
            state_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (cur.act == ACT_END) state_q <= S_IDLE;
          else if (cur.act == ACT_POLL) state_q <= S_POLL_CMD;
          else if (eng_ready) state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (eng_done) begin
            idx_q   <= idx_q + 2'd1;
            state_q <= S_ISSUE;
          end
        end
        S_POLL_CMD: if (eng_ready) state_q <= S_POLL_WAIT;
        S_POLL_RD:  if (eng_ready) state_q <= S_POLL_WAIT;
        S_POLL_WAIT: begin
          if (eng_done && !eng_req_was_rd_q) state_q <= S_POLL_RD;
          // Nothing else is sent until bit 7 reads 1
          else if (eng_done && eng_rdata[SR_READY_BIT]) begin
            idx_q   <= idx_q + 2'd1;
            state_q <= S_ISSUE;
          end else if (eng_done) state_q <= S_POLL_CMD;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Remembers which poll cycle is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) eng_req_was_rd_q <= 1'b0;
    else if (eng_valid && eng_ready) eng_req_was_rd_q <= eng_req.rd;
  end

  // Space model and captured data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      space_q <= SP_ARRAY;
      sr_q    <= 16'h0000;
      rdata_q <= 16'h0000;
    end else begin
      if (wr_fire && wa == REG_SPACE && ws[0] && !busy) space_q <= space_e'(wd[2:0]);
      else if (state_q == S_ISSUE && cur.act == ACT_END) space_q <= next_space_f(op_q, space_q);
      if (eng_done && eng_req_was_rd_q) begin
        if (state_q == S_POLL_WAIT || op_q == OP_STATUS) sr_q <= eng_rdata;
        else rdata_q <= eng_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  pin_sync #(.W(DW)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (fl_dq_i),
    .q       (dq_sync)
  );

  flash_cycle_engine #(.AW(AW), .DW(DW)) u_eng (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .req_valid (eng_valid),
    .req_ready (eng_ready),
    .req       (eng_req),
    .done      (eng_done),
    .rdata     (eng_rdata),
    .pins      (pins),
    .fl_addr   (fl_addr),
    .dq_o      (fl_dq_o),
    .dq_oe     (fl_dq_oe),
    .dq_i_sync (dq_sync)
  );

  assign fl_ce_n = pins.ce_n;
  assign fl_we_n = pins.we_n;
  assign fl_oe_n = pins.oe_n;

endmodule : prot_space_host

// File: prot_space_host_chk.sv
/* Pin and bus timing checker for prot_space_host.
   Bound to the top module; sees its ports only. */
module prot_space_host_chk #(
  parameter int DW = 16
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          fl_ce_n,
  input wire logic          fl_we_n,
  input wire logic          fl_oe_n,
  input wire logic          fl_dq_oe,
  input wire logic [DW-1:0] fl_dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_we_in_ce: assert property (!fl_we_n |-> !fl_ce_n)
    else $error("write strobe outside chip select");
  a_we_pulse: assert property ($fell(fl_we_n) |-> !fl_we_n[*5] ##1 fl_we_n)
    else $error("write pulse length wrong");
  a_dq_held: assert property (!fl_we_n |-> fl_dq_oe && $stable(fl_dq_o))
    else $error("command word moved during write");
  a_oe_no_drive: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n)
    else $error("host drives data during read");
  a_ce_setup: assert property ($fell(fl_ce_n) |-> (fl_we_n && fl_oe_n)[*2])
    else $error("no setup before strobe");
  a_ce_hold: assert property ($rose(fl_we_n) |-> !fl_ce_n[*3] ##1 fl_ce_n)
    else $error("hold after write wrong");
  a_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");

  c_write: cover property ($rose(fl_we_n));
  c_read: cover property ($rose(fl_oe_n));
  c_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule : prot_space_host_chk

bind prot_space_host prot_space_host_chk #(.DW(DW)) chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_oe(fl_dq_oe),
  .fl_dq_o(fl_dq_o));

// File: flash_prot_model.sv
/* Behavioural flash sitting in a protection space.
   Assumes host pins; busy_len status polls before a program ends. */
module flash_prot_model (
  input wire logic        ce_n,
  input wire logic        we_n,
  input wire logic        oe_n,
  input wire logic [25:0] addr,
  input wire logic [15:0] dq_o,
  input wire logic [3:0]  busy_len,
  output logic     [15:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  sr_q   = 8'h80;
  logic        pend_q = 1'b0;
  logic        srd_q  = 1'b0;
  logic [3:0]  cnt_q  = 4'h0;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] rd_v;

  // No pull-up: released bus shows the inverse of the last word
  assign rd_v = srd_q ? {8'h00, sr_q} : ~addr[15:0];
  assign dq_i = (!ce_n && !oe_n) ? rd_v : ~last_q;

  always @(posedge we_n) if (!ce_n) begin
    if (dq_o == 16'h0070) srd_q <= 1'b1;
    else if (cnt_q == 0) begin
      if (dq_o == 16'h0071) sr_q <= 8'h80;
      pend_q <= dq_o inside {16'h00a0, 16'h0080, 16'h0090};
      if (pend_q && dq_o inside {16'h0000, 16'h0001, 16'h0030}) begin
        cnt_q    <= busy_len;
        sr_q[7]  <= (busy_len == 4'h0);
      end
    end
  end

  always @(posedge oe_n) if (!ce_n) begin
    last_q <= rd_v;
    srd_q  <= 1'b0;
    if (srd_q && cnt_q != 0) cnt_q <= cnt_q - 4'h1;
    if (srd_q && cnt_q == 1) sr_q[7] <= 1'b1;
  end
endmodule : flash_prot_model

// File: prot_space_host_tb.sv
/* Self-checking bench for prot_space_host.
   Assumes the package, checker and flash model are compiled first. */
module prot_space_host_tb import prot_host_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] sp; logic [3:0] op; logic [3:0] bl; logic [7:0] nw;
    logic [15:0] d0; logic [15:0] d1; logic [25:0] a1; logic [2:0] spn;
  } row_s;
  localparam row_s ROWS [12] = '{
    '{1, 0, 0, 1, 16'hf0, 16'hf0, 0, 0}, '{1, 2, 0, 1, 16'h71, 16'h71, 26'h555, 1},
    '{4, 3, 0, 2, 16'h90, 16'h00, 0, 0}, '{3, 6, 0, 2, 16'ha0, 16'h00, 0, 3},
    '{4, 7, 0, 2, 16'ha0, 16'h00, 26'h40000, 4}, '{4, 8, 0, 2, 16'ha0, 16'h01, 26'h40000, 4},
    '{1, 4, 2, 5, 16'ha0, 16'h00, 26'h40000, 2}, '{1, 5, 2, 5, 16'h80, 16'h30, 0, 2},
    '{4, 1, 0, 1, 16'h70, 16'h70, 26'h555, 4}, '{4, 9, 0, 0, 0, 0, 0, 4},
    '{2, 2, 0, 1, 16'h71, 16'h71, 26'h555, 0}, '{3, 3, 0, 2, 16'h90, 16'h00, 0, 0}};
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, we_q = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hf, busy_len = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [25:0] fl_addr, wa [16];
  logic [15:0] fl_dq_o, fl_dq_i, wd [16];
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
  int failures = 0, checks = 0, nw = 0;

  prot_space_host dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_dq_i, .fl_ce_n, .fl_we_n,
    .fl_oe_n, .irq);
  flash_prot_model flash (.ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n), .addr(fl_addr),
    .dq_o(fl_dq_o), .busy_len(busy_len), .dq_i(fl_dq_i));

  initial begin
    forever #4 aclk = ~aclk;
  end

  // Logs every completed command write on the pins
  always @(posedge aclk) begin
    we_q <= fl_we_n;
    if (!we_q && fl_we_n) begin
      wd[nw[3:0]] <= fl_dq_o;
      wa[nw[3:0]] <= fl_addr;
      nw <= nw + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      // Late ready makes the slave hold its answer a cycle
      s_axi_bready <= s_axi_bvalid && !s_axi_bready;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= s_axi_rvalid && !s_axi_rready;
    end while (!(s_axi_rvalid && s_axi_rready));
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  // Bounded poll of the busy flag after a command
  task automatic run(input logic [2:0] sp, input logic [3:0] op);
    int n;
    wr(REG_SPACE, 32'(sp), rr);
    nw = 0;
    wr(REG_CMD, 32'(op), rr);
    n = 0;
    do begin
      rd(REG_STATUS, rv, rr);
      n++;
    end while (rv[ST_BUSY_BIT] && n < 500);
    chk(32'(n < 500), 32'h1);
  endtask : run

  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  initial begin
    #400us;
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_STATUS, rv, rr);
    chk(rv, 32'h0);
    chk(32'(fl_ce_n), 32'h1);
    wr(REG_ADDR, 32'h0004_0000, rr);
    foreach (ROWS[i]) begin
      busy_len = ROWS[i].bl;
      run(ROWS[i].sp, ROWS[i].op);
      chk(nw, 32'(ROWS[i].nw));
      chk(rv[ST_SPACE_LSB +: 3], ROWS[i].spn);
      if (ROWS[i].nw != 0) begin
        chk(wd[0], ROWS[i].d0);
        chk(wd[nw > 1], ROWS[i].d1);
        chk(wa[nw > 1], ROWS[i].a1);
      end
    end
    rd(REG_RDATA, rv, rr);
    chk(rv, 32'h0000_ffff);
    wr(8'h20, 32'h1, rr);
    chk(rr, RESP_SLVERR);
    rd(8'h24, rv, rr);
    chk(rr, RESP_SLVERR);
    rd(REG_IRQ_STAT, rv, rr);
    wr(REG_IRQ_MASK, 32'h1, rr);
    wr(REG_LOCK, 32'h24, rr);
    run(3'h3, 4'h6);
    chk(nw, 32'h0);
    chk(32'(irq), 32'h0);
    wr(REG_IRQ_MASK, 32'h3, rr);
    @(posedge aclk);
    chk(32'(irq), 32'h1);
    rd(REG_IRQ_STAT, rv, rr);
    chk(rv, 32'h2);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    run(3'h2, 4'h4);
    chk(nw, 32'h0);
    report_and_stop();
  end
endmodule : prot_space_host_tb
